// file: dv/olg_assertions.sv
// Concurrent checks on the ports of the output logic block.
`timescale 1ns/100ps
module olg_checker
    import olg_pkg::*;
(
    input wire logic                 clk,  // Clock.
    input wire logic                 rst,  // Reset.
    input wire logic [NUM_FUNCS-1:0] func_in,                  // Sources.
    input wire logic [FUNC_W-1:0]    combiner_input_a_sel,     // A code.
    input wire logic [FUNC_W-1:0]    combiner_input_b_sel,     // B code.
    input wire logic [1:0]           combiner_function_sel,    // Operator.
    input wire logic [FUNC_W-1:0]    term1_function_assign,    // T1 source.
    input wire logic [FUNC_W-1:0]    term2_function_assign,    // T2 source.
    input wire logic [FUNC_W-1:0]    relay_function_assign,    // Relay src.
    input wire logic [DLY_W-1:0]     term1_on_delay,           // T1 on.
    input wire logic [DLY_W-1:0]     term1_off_delay,          // T1 off.
    input wire logic [DLY_W-1:0]     term2_on_delay,           // T2 on.
    input wire logic [DLY_W-1:0]     relay_off_delay,          // Relay off.
    input wire logic [1:0]           fault_clear_response_sel, // Mode.
    input wire logic                 fault_clear_input,        // Pin.
    input wire logic                 tripped,                  // Trip.
    input wire logic                 running,                  // Run.
    input wire logic                 term1_out_q,              // T1.
    input wire logic                 term2_out_q,              // T2.
    input wire logic                 relay_out_q,              // Relay.
    input wire logic                 logic_result_q,           // Result.
    input wire logic                 motor_off_q,              // Stop.
    input wire logic                 trip_cancel_q             // Cancel.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic a = (combiner_input_a_sel < 4'h9) ?
                   func_in[combiner_input_a_sel] : 1'b0;
    wire logic b = (combiner_input_b_sel < 4'h9) ?
                   func_in[combiner_input_b_sel] : 1'b0;
    wire logic res = (combiner_function_sel == OP_AND) ? (a & b) :
                     (combiner_function_sel == OP_OR) ? (a | b) :
                     (combiner_function_sel == OP_XOR) ? (a ^ b) : 1'b0;
    wire logic t1z = term1_function_assign == FUNC_RUN &&
                     term1_on_delay == 10'h000 && term1_off_delay == 10'h000;
    AST_COMBINE: assert property (
        !$past(rst) |-> logic_result_q == $past(res)) else $error("bad result");
    AST_ZERO_ON: assert property (
        t1z && $rose(func_in[0]) |-> ##[2:4] term1_out_q) else $error("t1 on");
    AST_ZERO_OFF: assert property (
        t1z && $fell(func_in[0]) |-> ##[2:4] !term1_out_q) else $error("t1 off");
    AST_ON_WAIT: assert property (
        term2_function_assign == FUNC_ARRIVAL && term2_on_delay != 10'h000 &&
        $rose(func_in[1]) && !term2_out_q |=> !term2_out_q [*8])
        else $error("t2 early");
    AST_OFF_WAIT: assert property (
        relay_function_assign == 4'h2 && relay_off_delay != 10'h000 &&
        relay_out_q && $fell(func_in[2]) |=> relay_out_q [*8])
        else $error("relay early");
    AST_CLR_DROP: assert property (
        $rose(fault_clear_input) && term1_off_delay == 10'h000
        |-> ##[3:8] !term1_out_q) else $error("clear no drop");
    AST_CLR_HOLD: assert property (
        $rose(fault_clear_input) && relay_off_delay != 10'h000 && relay_out_q
        |=> relay_out_q [*8]) else $error("clear no hold");
    AST_CANCEL_RISE: assert property (
        tripped && fault_clear_response_sel != CLR_FALL_STOP &&
        $rose(fault_clear_input) |-> ##[2:6] trip_cancel_q) else $error("rise");
    AST_CANCEL_FALL: assert property (
        tripped && fault_clear_response_sel == CLR_FALL_STOP &&
        $fell(fault_clear_input) |-> ##[2:6] trip_cancel_q) else $error("fall");
    AST_CANCEL_ONE: assert property (
        trip_cancel_q |=> !trip_cancel_q) else $error("long cancel");
    AST_STOP: assert property (
        running && fault_clear_response_sel == CLR_RISE_STOP &&
        $rose(fault_clear_input) |-> ##[2:6] motor_off_q) else $error("no stop");
    AST_NO_STOP: assert property (
        running && fault_clear_response_sel == CLR_RISE_RUN && !motor_off_q &&
        $rose(fault_clear_input) |=> !motor_off_q [*8]) else $error("stopped");
    COV_XOR: cover property (combiner_function_sel == OP_XOR && logic_result_q);
    COV_HOLD: cover property ($rose(fault_clear_input) && relay_out_q);
    COV_CANCEL: cover property (trip_cancel_q);
endmodule
bind olg_top olg_checker u_chk (.clk(clk), .rst(rst), .func_in(func_in),
    .combiner_input_a_sel(combiner_input_a_sel),
    .combiner_input_b_sel(combiner_input_b_sel),
    .combiner_function_sel(combiner_function_sel),
    .term1_function_assign(term1_function_assign),
    .term2_function_assign(term2_function_assign),
    .relay_function_assign(relay_function_assign),
    .term1_on_delay(term1_on_delay), .term1_off_delay(term1_off_delay),
    .term2_on_delay(term2_on_delay), .relay_off_delay(relay_off_delay),
    .fault_clear_response_sel(fault_clear_response_sel),
    .fault_clear_input(fault_clear_input), .tripped(tripped),
    .running(running), .term1_out_q(term1_out_q), .term2_out_q(term2_out_q),
    .relay_out_q(relay_out_q), .logic_result_q(logic_result_q),
    .motor_off_q(motor_off_q), .trip_cancel_q(trip_cancel_q));

// file: dv/olg_out_reader.sv
// Model of the equipment that reads the three discrete outputs.
`timescale 1ns/100ps
module olg_out_reader (
    input  wire logic       clk,   // Clock.
    input  wire logic [2:0] pins,  // Relay, terminal 2, terminal 1.
    output logic      [2:0] seen_q // Levels as last sampled.
);
    always_ff @(posedge clk) begin
        seen_q <= pins;
    end
endmodule

// file: dv/tb.sv
// Self-checking bench for the output logic and delay block.
`timescale 1ns/100ps
module tb;
    import olg_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pin = 1'b0, trp = 1'b0, run = 1'b0, e;
    logic [8:0] fin = 9'h000;
    logic [3:0] asel = 4'h0, bsel = 4'h1, as1 = 4'h0, as2 = 4'h1, asr = 4'h2;
    logic [1:0] op = 2'h0, msel = 2'h0;
    logic [9:0] d1n = 10'h000, d1f = 10'h000, d2n = 10'h000, d2f = 10'h000;
    logic [9:0] drn = 10'h000, drf = 10'h000;
    logic t1, t2, ry, res, moff, canc;
    logic [2:0] seen;
    int n_fail = 0, n_compared = 0, cyc = 0, ncanc = 0, ndip = 0;
    always #2 clk = ~clk;
    olg_top DUT (.clk(clk), .rst(rst), .func_in(fin),
        .combiner_input_a_sel(asel), .combiner_input_b_sel(bsel),
        .combiner_function_sel(op), .term1_function_assign(as1),
        .term2_function_assign(as2), .relay_function_assign(asr),
        .term1_on_delay(d1n), .term1_off_delay(d1f), .term2_on_delay(d2n),
        .term2_off_delay(d2f), .relay_on_delay(drn), .relay_off_delay(drf),
        .fault_clear_response_sel(msel), .fault_clear_input(pin),
        .tripped(trp), .running(run), .term1_out_q(t1), .term2_out_q(t2),
        .relay_out_q(ry), .logic_result_q(res), .motor_off_q(moff),
        .trip_cancel_q(canc));
    olg_out_reader u_reader (.clk(clk), .pins({ry, t2, t1}), .seen_q(seen));
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic do_rst();
        rst = 1'b1;
        step(8);
        rst = 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (canc === 1'b1)
            ncanc++;
        if (t1 === 1'b0)
            ndip++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        {as1, as2, asr} = {3{FUNC_LOGIC}};
        do_rst();
        for (int o = 0; o < 4; o++) begin
            for (int v = 0; v < 4; v++) begin
                op = o[1:0];
                fin[1:0] = v[1:0];
                step(6);
                e = (o == 0) ? (v == 3) : (o == 1) ? (v != 0) :
                    (o == 2) ? (v == 1 || v == 2) : 1'b0;
                chk({seen, res}, {4{e}});
            end
        end
        $display("test 1 done");
        op = OP_AND;
        asel = 4'h4;
        bsel = 4'h7;
        fin = 9'h090;
        step(6);
        chk({seen, res}, 4'hF);
        fin = 9'h010;
        step(6);
        chk({seen, res}, 4'h0);
        asel = 4'h9;
        fin = 9'h081;
        step(6);
        chk({seen, res}, 4'h0);
        $display("test 2 done");
        {asel, bsel, as1, as2, asr} = {4'h0, 4'h1, 4'h0, 4'h1, 4'h2};
        fin = 9'h000;
        d2n = 10'h001;
        drf = DLY_MAX;
        do_rst();
        fin = 9'h007;
        step(10);
        chk({seen, res}, 4'hB);
        fin = 9'h000;
        step(10);
        chk({seen, res}, 4'h8);
        $display("test 3 done");
        {d2n, drf, asr, fin, trp, run} = {10'h000, 10'h005, 4'h0, 9'h001, 2'h3};
        for (int m = 0; m < 3; m++) begin
            msel = m[1:0];
            do_rst();
            step(8);
            ncanc = 0;
            ndip = 0;
            pin = 1'b1;
            step(10);
            chk({seen, moff}, {3'b101, m != 2});
            chk(ndip[3:0], 4'h1);
            chk(ncanc[3:0], (m == 1) ? 4'h0 : 4'h1);
            pin = 1'b0;
            step(10);
            chk(ncanc[3:0], 4'h1);
        end
        $display("test 4 done");
        close_out();
    end
endmodule

// file: verilog/olg_delay_timer.sv
// One output's ON and OFF transition delay with fault-clear hold.
`timescale 1ns/100ps
module olg_delay_timer
    import olg_pkg::*;
(
    input  wire logic             clk,       // System clock.
    input  wire logic             rst,       // Asynchronous reset.
    input  wire logic             tick,      // One 0.1 s tick pulse.
    input  wire logic             src,       // Internal source level.
    input  wire logic [DLY_W-1:0] on_dly,    // ON delay in ticks.
    input  wire logic [DLY_W-1:0] off_dly,   // OFF delay in ticks.
    input  wire logic             clr_start, // Fault clear turned on.
    output logic                  out_q      // Delayed output level.
);

    logic [DLY_W-1:0] on_cnt_q;
    logic [DLY_W-1:0] off_cnt_q;
    logic [3:0]       hold_cnt_q;
    logic             hold_q;
    logic             src_q;
    logic             src_edge;
    logic             on_done;
    logic             off_done;
    logic             hold_done;

    assign src_edge = src ^ src_q;
    assign on_done = (on_cnt_q >= on_dly);
    assign off_done = (off_cnt_q >= off_dly);
    assign hold_done = (hold_cnt_q >= 4'(HOLD_TICKS));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_cnt_q <= '0;
            off_cnt_q <= '0;
            src_q <= 1'b0;
        end else begin
            src_q <= src;
            if (src_edge) begin
                on_cnt_q <= '0;
                off_cnt_q <= '0;
            end else if (tick) begin
                if (src && !on_done)
                    on_cnt_q <= on_cnt_q + 1'b1;
                if (!src && !off_done)
                    off_cnt_q <= off_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b0;
            hold_cnt_q <= 4'h0;
        end else if (clr_start && out_q && off_dly != '0) begin
            hold_q <= 1'b1;
            hold_cnt_q <= 4'h0;
        end else if (hold_q && tick) begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
            if (hold_done)
                hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (clr_start && off_dly == '0) begin
            out_q <= 1'b0;
        end else if (hold_q) begin
            out_q <= !hold_done || !tick;
        end else if (src && !src_edge && on_done) begin
            out_q <= 1'b1;
        end else if (!src && !src_edge && off_done) begin
            out_q <= 1'b0;
        end
    end

endmodule

// file: verilog/olg_pkg.sv
// Constants shared by the output logic and delay block.
//
// Contract
// - The combiner forms AND for code 00, OR for code 01 and XOR for 02.
// - The combiner output follows the full two-input truth table.
// - Combiner input A selects a function and defaults to code 00, run.
// - Combiner input B selects a function, default code 01, arrival.
// - Combiner inputs come from nine functions, never the result.
// - Each of the three outputs may be assigned the combined result.
// - Every output has its own ON delay and its own OFF delay.
// - Delays run 0.0 to 100.0 s in 0.1 s steps, and zero means no delay.
// - A nonzero ON delay postpones turn-on after the source rises.
// - A nonzero OFF delay postpones turn-off after the source falls.
// - Without OFF delays, fault clear drops outputs at once, and the motor in codes 00 and 01.
// - An output with an OFF delay stays on about 1 s after fault clear.
// - The clear select code picks the cancel edge and the stop effect.
package olg_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_PERIOD_MS = 100;
    localparam int TICK_CYCLES =
        TICK_PERIOD_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int HOLD_PERIOD_MS = 1000;
    localparam int HOLD_TICKS = HOLD_PERIOD_MS / TICK_PERIOD_MS;

    // -------------------------------------------------------------------
    // Widths and codes
    // -------------------------------------------------------------------
    localparam int DLY_W = 10;
    localparam logic [9:0] DLY_MAX = 10'h3E8;
    localparam logic [9:0] DLY_RESET = 10'h000;
    localparam int FUNC_W = 4;
    localparam int NUM_FUNCS = 9;
    localparam logic [3:0] FUNC_RUN = 4'h0;
    localparam logic [3:0] FUNC_ARRIVAL = 4'h1;
    localparam logic [3:0] FUNC_LOGIC = 4'h9;
    localparam logic [3:0] SEL_A_RESET = 4'h0;
    localparam logic [3:0] SEL_B_RESET = 4'h1;
    localparam logic [1:0] OP_AND = 2'h0;
    localparam logic [1:0] OP_OR = 2'h1;
    localparam logic [1:0] OP_XOR = 2'h2;
    localparam logic [1:0] CLR_RISE_STOP = 2'h0;
    localparam logic [1:0] CLR_FALL_STOP = 2'h1;
    localparam logic [1:0] CLR_RISE_RUN = 2'h2;
    localparam int NUM_OUTS = 3;

endpackage

// file: verilog/olg_top.sv
// Logic combiner, output routing and delays for the discrete outputs.
`timescale 1ns/100ps
module olg_top
    import olg_pkg::*;
(
    input  wire logic              clk,                     // 250 MHz clock.
    input  wire logic              rst,                     // Async reset.
    input  wire logic [NUM_FUNCS-1:0] func_in,              // Nine functions.
    input  wire logic [FUNC_W-1:0] combiner_input_a_sel,    // Input A code.
    input  wire logic [FUNC_W-1:0] combiner_input_b_sel,    // Input B code.
    input  wire logic [1:0]        combiner_function_sel,   // AND/OR/XOR.
    input  wire logic [FUNC_W-1:0] term1_function_assign,   // Term 1 source.
    input  wire logic [FUNC_W-1:0] term2_function_assign,   // Term 2 source.
    input  wire logic [FUNC_W-1:0] relay_function_assign,   // Relay source.
    input  wire logic [DLY_W-1:0]  term1_on_delay,          // Ticks of 0.1 s.
    input  wire logic [DLY_W-1:0]  term1_off_delay,         // Ticks of 0.1 s.
    input  wire logic [DLY_W-1:0]  term2_on_delay,          // Ticks of 0.1 s.
    input  wire logic [DLY_W-1:0]  term2_off_delay,         // Ticks of 0.1 s.
    input  wire logic [DLY_W-1:0]  relay_on_delay,          // Ticks of 0.1 s.
    input  wire logic [DLY_W-1:0]  relay_off_delay,         // Ticks of 0.1 s.
    input  wire logic [1:0]        fault_clear_response_sel, // Clear mode.
    input  wire logic              fault_clear_input,       // Pin, async.
    input  wire logic              tripped,                 // Trip state.
    input  wire logic              running,                 // Drive running.
    output logic                   term1_out_q,             // Terminal 1.
    output logic                   term2_out_q,             // Terminal 2.
    output logic                   relay_out_q,             // Relay drive.
    output logic                   logic_result_q,          // Combined level.
    output logic                   motor_off_q,             // Motor stop.
    output logic                   trip_cancel_q            // Cancel pulse.
);

    // -------------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------------
    // nine-way select
    function automatic logic pick(input logic [NUM_FUNCS-1:0] f,
                                  input logic [FUNC_W-1:0] s);
        pick = (s < 4'(NUM_FUNCS)) ? f[s] : 1'b0;
    endfunction

    function automatic logic clamp_hi(input logic [DLY_W-1:0] d);
        clamp_hi = (d > DLY_MAX);
    endfunction

    // -------------------------------------------------------------------
    // Input synchronisation and tick
    // -------------------------------------------------------------------
    logic        clr_meta_q;
    logic        clr_sync_q;
    logic        clr_prev_q;
    logic [24:0] tick_cnt_q;
    logic        tick_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_meta_q <= 1'b0;
            clr_sync_q <= 1'b0;
            clr_prev_q <= 1'b0;
        end else begin
            clr_meta_q <= fault_clear_input;
            clr_sync_q <= clr_meta_q;
            clr_prev_q <= clr_sync_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 25'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 25'h0000001;
            tick_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Combiner and routing
    // -------------------------------------------------------------------
    logic in_a;
    logic in_b;
    logic comb;
    logic clr_rise;
    logic clr_fall;
    logic [NUM_FUNCS:0] route_src;
    logic [NUM_OUTS-1:0] src;
    logic [NUM_OUTS-1:0] dly_out;
    logic [DLY_W-1:0] on_d [NUM_OUTS];
    logic [DLY_W-1:0] off_d [NUM_OUTS];

    assign in_a = pick(func_in, combiner_input_a_sel);
    assign in_b = pick(func_in, combiner_input_b_sel);
    assign comb = (combiner_function_sel == OP_AND) ? (in_a & in_b) :
                  (combiner_function_sel == OP_OR)  ? (in_a | in_b) :
                  (combiner_function_sel == OP_XOR) ? (in_a ^ in_b) : 1'b0;

    assign route_src = {comb, func_in};
    assign src[0] = (term1_function_assign <= FUNC_LOGIC) ?
                    route_src[term1_function_assign] : 1'b0;
    assign src[1] = (term2_function_assign <= FUNC_LOGIC) ?
                    route_src[term2_function_assign] : 1'b0;
    assign src[2] = (relay_function_assign <= FUNC_LOGIC) ?
                    route_src[relay_function_assign] : 1'b0;

    assign on_d[0] = clamp_hi(term1_on_delay) ? DLY_MAX : term1_on_delay;
    assign off_d[0] = clamp_hi(term1_off_delay) ? DLY_MAX : term1_off_delay;
    assign on_d[1] = clamp_hi(term2_on_delay) ? DLY_MAX : term2_on_delay;
    assign off_d[1] = clamp_hi(term2_off_delay) ? DLY_MAX : term2_off_delay;
    assign on_d[2] = clamp_hi(relay_on_delay) ? DLY_MAX : relay_on_delay;
    assign off_d[2] = clamp_hi(relay_off_delay) ? DLY_MAX : relay_off_delay;

    assign clr_rise = clr_sync_q & ~clr_prev_q;
    assign clr_fall = ~clr_sync_q & clr_prev_q;

    // -------------------------------------------------------------------
    // Delayed outputs
    // -------------------------------------------------------------------
    for (genvar i = 0; i < NUM_OUTS; i++) begin : g_out
        olg_delay_timer u_dly (
            .clk       (clk),
            .rst       (rst),
            .tick      (tick_q),
            .src       (src[i]),
            .on_dly    (on_d[i]),
            .off_dly   (off_d[i]),
            .clr_start (clr_rise),
            .out_q     (dly_out[i])
        );
    end

    // -------------------------------------------------------------------
    // Output registers and fault clear
    // -------------------------------------------------------------------
    logic cancel_edge;
    logic stop_req;

    assign cancel_edge = (fault_clear_response_sel == CLR_FALL_STOP) ?
                         clr_fall : clr_rise;
    assign stop_req = (fault_clear_response_sel != CLR_RISE_RUN) &&
                      running && clr_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            term1_out_q <= 1'b0;
            term2_out_q <= 1'b0;
            relay_out_q <= 1'b0;
            logic_result_q <= 1'b0;
            motor_off_q <= 1'b0;
            trip_cancel_q <= 1'b0;
        end else begin
            term1_out_q <= dly_out[0];
            term2_out_q <= dly_out[1];
            relay_out_q <= dly_out[2];
            logic_result_q <= comb;
            if (stop_req)
                motor_off_q <= 1'b1;
            else if (!running)
                motor_off_q <= 1'b0;
            trip_cancel_q <= cancel_edge && tripped;
        end
    end

endmodule
